// File: logic/mdah_params.svh
// offsets, reset values and timing counts of the motor drive alarm handler
`ifndef MDAH_PARAMS_SVH
`define MDAH_PARAMS_SVH

// ************************************************************
// register offsets (register indices, byte address = 4 x index)
// ************************************************************
`define MDAH_IDX_OVERLOAD_THR 16'h0180
`define MDAH_IDX_POSDEV_THR 16'h0181
`define MDAH_IDX_NETLOSS_EN 16'h6188
`define MDAH_ADDR_OVERLOAD_THR 18'h00600
`define MDAH_ADDR_POSDEV_THR 18'h00604
`define MDAH_ADDR_NETLOSS_EN 18'h18620
`define MDAH_ADDR_ALARM_CODE 18'h00700
`define MDAH_ADDR_STATUS 18'h00704
`define MDAH_ADDR_EVENT 18'h00708
`define MDAH_ADDR_MASK 18'h0070c

// ************************************************************
// reset values
// ************************************************************
`define MDAH_RST_OVERLOAD_THR 32'h00000032
`define MDAH_RST_POSDEV_THR 32'h0000012c
`define MDAH_RST_NETLOSS_EN 32'h00000001
`define MDAH_RST_MASK 8'h00

// ************************************************************
// threshold limits and timing
// ************************************************************
`define MDAH_OVERLOAD_MIN 32'h00000001
`define MDAH_OVERLOAD_MAX 32'h0000012c
`define MDAH_POSDEV_MIN 32'h00000001
`define MDAH_POSDEV_MAX 32'h00007530
`define MDAH_CLK_HZ 25000000
`define MDAH_OVERLOAD_UNIT_MS 100
`define MDAH_TICK_CYCLES ((`MDAH_CLK_HZ / 1000) * `MDAH_OVERLOAD_UNIT_MS)
`define MDAH_BLINKS_STD 4'h7

// ************************************************************
// alarm codes
// ************************************************************
`define MDAH_CODE_NONE 8'h00
`define MDAH_CODE_COMBO 8'h45
`define MDAH_CODE_MECH_OT 8'h6d
`define MDAH_CODE_OPDATA 8'h70
`define MDAH_CODE_GEAR 8'h71
`define MDAH_CODE_WRAP 8'h72
`define MDAH_CODE_NETLOSS 8'h81
`define MDAH_CODE_NETMOD 8'h82
`define MDAH_CODE_OVERLOAD 8'h30
`define MDAH_CODE_POSDEV 8'h10

// ************************************************************
// event bit positions
// ************************************************************
`define MDAH_EV_RAISE 0
`define MDAH_EV_CLEAR 1
`define MDAH_EV_REFUSED 2

`endif

// File: logic/mdah_pkg.sv
// types of the motor drive alarm handler
package mdah_pkg;

    // alarm state, gray coded along idle -> active -> clearing
    typedef enum logic [1:0] {
        MDAH_IDLE = 2'b00,
        MDAH_ACTIVE = 2'b01,
        MDAH_CLEARING = 2'b11,
        MDAH_LOCKED = 2'b10
    } mdah_state_t;

endpackage : mdah_pkg

// File: logic/mdah_alarm_handler.sv
// alarm detection, latching and recovery for a stepper motor drive
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "mdah_params.svh"
module mdah_alarm_handler (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic [17:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic alarm_clear_input,
    input wire logic running,
    input wire logic net_conn_lost,
    input wire logic net_module_fault,
    input wire logic homed,
    input wire logic at_mech_limit,
    input wire logic op_start,
    input wire logic op_speed_zero,
    input wire logic op_over_limit,
    input wire logic op_wrap,
    input wire logic wrap_enabled,
    input wire logic gear_res_bad,
    input wire logic power_up,
    input wire logic wrap_range_bad,
    input wire logic motor_ac_type,
    input wire logic motor_small_frame,
    input wire logic supply_48v,
    input wire logic overloaded,
    input wire logic [31:0] position_deviation,
    input wire logic motion_request,
    output logic alarm_clear_status_output,
    output logic ready_output,
    output logic motion_output,
    output logic motor_current_on,
    output logic motor_stop,
    output logic [3:0] led_blinks,
    output logic irq
);

    // ************************************************************
    // pin synchronisers, three stages, change taken when stages 2 and 3 agree
    // ************************************************************
    localparam int NPIN = 17;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_ff;
    logic [NPIN-1:0] s2_ff;
    logic [NPIN-1:0] s3_ff;
    logic [NPIN-1:0] pin_ff;
    logic [NPIN-1:0] nxt_pin;

    assign pin_raw = {alarm_clear_input, running, net_conn_lost, net_module_fault, homed,
                      at_mech_limit, op_start, op_speed_zero, op_over_limit, op_wrap,
                      wrap_enabled, gear_res_bad, power_up, wrap_range_bad,
                      motor_ac_type, motor_small_frame, supply_48v};
    assign nxt_pin = (s2_ff & s3_ff) | (pin_ff & (s2_ff | s3_ff));

    // sync chain
    always_ff @(posedge clock) begin
        if (reset) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            pin_ff <= '0;
        end else if (clock_enable) begin
            s1_ff <= pin_raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= nxt_pin;
        end
    end

    logic p_clr, p_run, p_nloss, p_nmod, p_homed, p_limit, p_start, p_spd0;
    logic p_over, p_wrap, p_wrapen, p_gear, p_pwrup, p_wrapbad, p_ac, p_small, p_48v;
    assign {p_clr, p_run, p_nloss, p_nmod, p_homed, p_limit, p_start, p_spd0, p_over,
            p_wrap, p_wrapen, p_gear, p_pwrup, p_wrapbad, p_ac, p_small, p_48v} = pin_ff;

    // ************************************************************
    // register file
    // ************************************************************
    logic [31:0] ovl_thr_ff;
    logic [31:0] posdev_thr_ff;
    logic netloss_en_ff;
    logic [7:0] mask_ff;
    logic [7:0] event_ff;
    logic [7:0] nxt_event;
    logic [31:0] nxt_rdata;
    logic [31:0] wdata_ovl;
    logic [31:0] wdata_pdv;
    logic [7:0] ev_set;
    // full-width reset word, only its enable bit is kept
    localparam logic [31:0] NLE_RST = `MDAH_RST_NETLOSS_EN;

    wire sel_ovl = reg_addr == `MDAH_ADDR_OVERLOAD_THR;
    wire sel_pdv = reg_addr == `MDAH_ADDR_POSDEV_THR;
    wire sel_nle = reg_addr == `MDAH_ADDR_NETLOSS_EN;
    wire sel_code = reg_addr == `MDAH_ADDR_ALARM_CODE;
    wire sel_stat = reg_addr == `MDAH_ADDR_STATUS;
    wire sel_evt = reg_addr == `MDAH_ADDR_EVENT;
    wire sel_msk = reg_addr == `MDAH_ADDR_MASK;

    // thresholds saturate into their legal ranges
    assign wdata_ovl = (reg_wdata < `MDAH_OVERLOAD_MIN) ? `MDAH_OVERLOAD_MIN :
                       (reg_wdata > `MDAH_OVERLOAD_MAX) ? `MDAH_OVERLOAD_MAX : reg_wdata;
    assign wdata_pdv = (reg_wdata < `MDAH_POSDEV_MIN) ? `MDAH_POSDEV_MIN :
                       (reg_wdata > `MDAH_POSDEV_MAX) ? `MDAH_POSDEV_MAX : reg_wdata;

    // configuration registers
    always_ff @(posedge clock) begin
        if (reset) begin
            ovl_thr_ff <= `MDAH_RST_OVERLOAD_THR;
            posdev_thr_ff <= `MDAH_RST_POSDEV_THR;
            netloss_en_ff <= NLE_RST[0];
            mask_ff <= `MDAH_RST_MASK;
        end else if (clock_enable && reg_write) begin
            if (sel_ovl) ovl_thr_ff <= wdata_ovl;
            if (sel_pdv) posdev_thr_ff <= wdata_pdv;
            if (sel_nle) netloss_en_ff <= reg_wdata[0];
            if (sel_msk) mask_ff <= reg_wdata[7:0];
        end
    end

    // ************************************************************
    // fault detection
    // ************************************************************
    logic [31:0] tick_cnt_ff;
    logic [31:0] ovl_cnt_ff;
    wire tick = tick_cnt_ff == 32'(`MDAH_TICK_CYCLES - 1);

    // overload time accumulated in 0.1 s ticks while overloaded
    always_ff @(posedge clock) begin
        if (reset) begin
            tick_cnt_ff <= '0;
            ovl_cnt_ff <= '0;
        end else if (clock_enable) begin
            tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 32'h1;
            if (!overloaded) ovl_cnt_ff <= '0;
            else if (tick && ovl_cnt_ff < ovl_thr_ff) ovl_cnt_ff <= ovl_cnt_ff + 32'h1;
        end
    end

    wire f_ovl = overloaded && ovl_cnt_ff >= ovl_thr_ff;
    wire f_pdv = position_deviation > posdev_thr_ff;
    wire f_nloss = p_nloss && p_run && netloss_en_ff;
    wire f_nmod = p_nmod;
    wire f_mech = p_homed && p_limit;
    wire f_opd = p_start && (p_spd0 || p_over || (p_wrap && !p_wrapen));
    wire f_gear = p_gear;
    wire f_wrap = p_pwrup && p_wrapbad;
    wire f_combo = p_ac || (p_small && p_48v);

    // priority encoder: power-cycle faults first
    logic [7:0] new_code;
    assign new_code = f_nmod ? `MDAH_CODE_NETMOD :
                      f_gear ? `MDAH_CODE_GEAR :
                      f_wrap ? `MDAH_CODE_WRAP :
                      f_combo ? `MDAH_CODE_COMBO :
                      f_mech ? `MDAH_CODE_MECH_OT :
                      f_opd ? `MDAH_CODE_OPDATA :
                      f_nloss ? `MDAH_CODE_NETLOSS :
                      f_ovl ? `MDAH_CODE_OVERLOAD :
                      f_pdv ? `MDAH_CODE_POSDEV : `MDAH_CODE_NONE;
    wire any_fault = new_code != `MDAH_CODE_NONE;
    wire new_nonexc = new_code == `MDAH_CODE_NETMOD || new_code == `MDAH_CODE_GEAR ||
                      new_code == `MDAH_CODE_WRAP;

    // ************************************************************
    // alarm state machine
    // ************************************************************
    mdah_pkg::mdah_state_t state_ff;
    mdah_pkg::mdah_state_t nxt_state;
    logic [7:0] code_ff;
    logic nonexc_ff;
    logic clr_d_ff;
    wire clr_rise = p_clr && !clr_d_ff;
    wire accept = (state_ff == mdah_pkg::MDAH_IDLE) && any_fault;
    wire do_clear = (state_ff == mdah_pkg::MDAH_ACTIVE) && clr_rise && !any_fault;
    wire refused = (state_ff == mdah_pkg::MDAH_LOCKED) && clr_rise;

    // next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            mdah_pkg::MDAH_IDLE: begin
                if (any_fault) nxt_state = new_nonexc ? mdah_pkg::MDAH_LOCKED
                                                      : mdah_pkg::MDAH_ACTIVE;
            end
            mdah_pkg::MDAH_ACTIVE: begin
                if (do_clear) nxt_state = mdah_pkg::MDAH_CLEARING;
            end
            mdah_pkg::MDAH_CLEARING: begin
                if (!p_clr) nxt_state = mdah_pkg::MDAH_IDLE;
            end
            mdah_pkg::MDAH_LOCKED: begin
                nxt_state = mdah_pkg::MDAH_LOCKED;
            end
            default: nxt_state = mdah_pkg::MDAH_IDLE;
        endcase
    end

    // alarm latch: code held until applicable reset
    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff <= mdah_pkg::MDAH_IDLE;
            code_ff <= `MDAH_CODE_NONE;
            nonexc_ff <= 1'b0;
            clr_d_ff <= 1'b0;
        end else if (clock_enable) begin
            state_ff <= nxt_state;
            clr_d_ff <= p_clr;
            if (accept) begin
                code_ff <= new_code;
                nonexc_ff <= new_nonexc;
            end else if (do_clear) begin
                code_ff <= `MDAH_CODE_NONE;
                nonexc_ff <= 1'b0;
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    wire alarm_now = accept || state_ff == mdah_pkg::MDAH_ACTIVE ||
                     state_ff == mdah_pkg::MDAH_LOCKED;
    wire nonexc_now = accept ? new_nonexc : nonexc_ff;

    // drive outputs from flops
    always_ff @(posedge clock) begin
        if (reset) begin
            alarm_clear_status_output <= 1'b1;
            ready_output <= 1'b1;
            motion_output <= 1'b0;
            motor_current_on <= 1'b1;
            motor_stop <= 1'b0;
            led_blinks <= 4'h0;
        end else if (clock_enable) begin
            alarm_clear_status_output <= !alarm_now;
            ready_output <= !alarm_now;
            motion_output <= !alarm_now && motion_request;
            motor_stop <= alarm_now;
            motor_current_on <= !(alarm_now && nonexc_now);
            led_blinks <= alarm_now ? `MDAH_BLINKS_STD : 4'h0;
        end
    end

    // ************************************************************
    // events, mask, interrupt (set wins over write-one-clear)
    // ************************************************************
    assign ev_set = {5'h00, refused, do_clear, accept};
    assign nxt_event = (event_ff & ~((reg_write && sel_evt) ? reg_wdata[7:0] : 8'h00)) | ev_set;

    // event latch and interrupt
    always_ff @(posedge clock) begin
        if (reset) begin
            event_ff <= 8'h00;
            irq <= 1'b0;
        end else if (clock_enable) begin
            event_ff <= nxt_event;
            irq <= |(nxt_event & mask_ff);
        end
    end

    // read mux, unmapped reads zero
    assign nxt_rdata = sel_ovl ? ovl_thr_ff :
                       sel_pdv ? posdev_thr_ff :
                       sel_nle ? {31'h0, netloss_en_ff} :
                       sel_code ? {24'h0, code_ff} :
                       sel_stat ? {26'h0, state_ff, nonexc_ff, any_fault,
                                   motor_current_on, alarm_clear_status_output} :
                       sel_evt ? {24'h0, event_ff} :
                       sel_msk ? {24'h0, mask_ff} : 32'h0;

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 32'h0;
        end else if (clock_enable) begin
            reg_rdata <= reg_read ? nxt_rdata : 32'h0;
        end
    end

endmodule : mdah_alarm_handler

// File: tb/mdah_alarm_handler_sva.sv
// port assertions of the motor drive alarm handler
`timescale 1ns/1ps
module mdah_alarm_handler_chk (
    input wire logic clock,
    input wire logic reset,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic alarm_clear_input,
    input wire logic alarm_clear_status_output,
    input wire logic ready_output,
    input wire logic motion_output,
    input wire logic motor_current_on,
    input wire logic motor_stop,
    input wire logic [3:0] led_blinks
);
    // ************************************************************
    // alarm outputs and read port
    // ************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    property p_stop;
        !alarm_clear_status_output |-> motor_stop && !ready_output;
    endproperty
    a_stop: assert property (p_stop) else $error("motor not stopped in alarm");
    property p_motion;
        !alarm_clear_status_output |-> !motion_output;
    endproperty
    a_motion: assert property (p_motion) else $error("motion output high in alarm");
    property p_blink;
        !alarm_clear_status_output |-> led_blinks == 4'h7;
    endproperty
    a_blink: assert property (p_blink) else $error("wrong blink count in alarm");
    property p_idle;
        alarm_clear_status_output |-> !motor_stop && led_blinks == 4'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("alarm signs without alarm");
    property p_ready;
        $rose(alarm_clear_status_output) |-> ready_output && motor_current_on;
    endproperty
    a_ready: assert property (p_ready) else $error("clear without ready or current");
    property p_clear_cause;
        $rose(alarm_clear_status_output) |-> $past(alarm_clear_input, 2);
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("alarm left without clear");
    property p_cut_cause;
        $fell(motor_current_on) |-> !alarm_clear_status_output;
    endproperty
    a_cut_cause: assert property (p_cut_cause) else $error("current cut without alarm");
    property p_cut_hold;
        !motor_current_on |=> !motor_current_on;
    endproperty
    a_cut_hold: assert property (p_cut_hold) else $error("current back before power cycle");
    property p_rdata;
        !$past(reg_read) |-> reg_rdata == 32'h0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
    c_alarm: cover property ($fell(alarm_clear_status_output));
    c_clear: cover property ($rose(alarm_clear_status_output));
    c_cut: cover property ($fell(motor_current_on));
endmodule : mdah_alarm_handler_chk

bind mdah_alarm_handler mdah_alarm_handler_chk u_chk (.clock(clock), .reset(reset),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .alarm_clear_input(alarm_clear_input),
    .alarm_clear_status_output(alarm_clear_status_output), .ready_output(ready_output),
    .motion_output(motion_output), .motor_current_on(motor_current_on),
    .motor_stop(motor_stop), .led_blinks(led_blinks));

// File: tb/mdah_host_model.sv
// host controller model driving the alarm clear handshake
`timescale 1ns/1ps
module mdah_host_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic clr_go,
    input wire logic alarm_clear_status_output,
    output logic alarm_clear_input,
    output logic motion_request,
    output logic done
);
    logic [1:0] st_ff;
    logic [4:0] cnt_ff;
    // drop command, raise clear, hold until status, give up after a while
    always_ff @(posedge clock) begin
        if (reset) begin
            st_ff <= 2'h0;
            cnt_ff <= 5'h00;
            alarm_clear_input <= 1'b0;
            motion_request <= 1'b1;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (st_ff)
                2'h0: if (clr_go) begin
                    motion_request <= 1'b0;
                    st_ff <= 2'h1;
                end
                2'h1: begin
                    alarm_clear_input <= 1'b1;
                    cnt_ff <= 5'h00;
                    st_ff <= 2'h2;
                end
                2'h2: begin
                    cnt_ff <= cnt_ff + 5'h01;
                    if (alarm_clear_status_output || cnt_ff == 5'h18) begin
                        alarm_clear_input <= 1'b0;
                        st_ff <= 2'h3;
                    end
                end
                default: begin
                    motion_request <= 1'b1;
                    done <= 1'b1;
                    st_ff <= 2'h0;
                end
            endcase
        end
    end
endmodule : mdah_host_model

// File: tb/mdah_alarm_handler_bench.sv
// self-checking bench of the motor drive alarm handler
`timescale 1ns/1ps
`include "mdah_params.svh"
module mdah_alarm_handler_bench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [17:0] reg_addr = 18'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] pins = 16'h0;
    logic [31:0] pos_dev = 32'h0;
    logic clr_go = 1'b0;
    logic ovl = 1'b0;
    logic [31:0] reg_rdata, d;
    logic clr_in, motion_req, host_done, st_out, rdy, mot, cur, stp, irq, v0;
    logic [3:0] blinks;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [15:0] pat [10] = '{16'h0003, 16'h0018, 16'h0060, 16'h00a0, 16'h0120,
        16'h2000, 16'hc000, 16'h0004, 16'h0400, 16'h1800};
    logic [7:0] cod [10] = '{8'h81, 8'h6d, 8'h70, 8'h70, 8'h70, 8'h45, 8'h45, 8'h82, 8'h71, 8'h72};
    always #20 clock = ~clock;
    mdah_alarm_handler DUT (.clock(clock), .reset(reset), .clock_enable(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .alarm_clear_input(clr_in), .running(pins[0]),
        .net_conn_lost(pins[1]), .net_module_fault(pins[2]), .homed(pins[3]),
        .at_mech_limit(pins[4]), .op_start(pins[5]), .op_speed_zero(pins[6]),
        .op_over_limit(pins[7]), .op_wrap(pins[8]), .wrap_enabled(pins[9]),
        .gear_res_bad(pins[10]), .power_up(pins[11]), .wrap_range_bad(pins[12]),
        .motor_ac_type(pins[13]), .motor_small_frame(pins[14]), .supply_48v(pins[15]),
        .overloaded(ovl), .position_deviation(pos_dev), .motion_request(motion_req),
        .alarm_clear_status_output(st_out), .ready_output(rdy), .motion_output(mot),
        .motor_current_on(cur), .motor_stop(stp), .led_blinks(blinks), .irq(irq));
    mdah_host_model u_host (.clock(clock), .reset(reset), .clr_go(clr_go),
        .alarm_clear_status_output(st_out), .alarm_clear_input(clr_in),
        .motion_request(motion_req), .done(host_done));
    // ************************************************************
    // access and check tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [17:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rc(input string nm, input logic [17:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
        chk(nm, d, exp);
    endtask : rc
    task automatic wait_st(input logic v);
        for (int i = 0; i < 30 && st_out !== v; i++) begin
            @(posedge clock);
            #1;
        end
    endtask : wait_st
    // one clear handshake through the host model
    task automatic clear();
        @(posedge clock);
        clr_go <= 1'b1;
        @(posedge clock);
        clr_go <= 1'b0;
        for (int i = 0; i < 60 && host_done !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        #1;
    endtask : clear
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            close_out();
        end
    end
    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rc("ovl_rst", `MDAH_ADDR_OVERLOAD_THR, `MDAH_RST_OVERLOAD_THR);
        rc("dev_rst", `MDAH_ADDR_POSDEV_THR, `MDAH_RST_POSDEV_THR);
        rc("net_rst", `MDAH_ADDR_NETLOSS_EN, `MDAH_RST_NETLOSS_EN);
        rc("code_rst", `MDAH_ADDR_ALARM_CODE, 32'h0);
        wr(18'h00800, 32'hffffffff);
        rc("unmapped", 18'h00800, 32'h0);
        wr(`MDAH_ADDR_OVERLOAD_THR, 32'h0);
        rc("ovl_min", `MDAH_ADDR_OVERLOAD_THR, `MDAH_OVERLOAD_MIN);
        wr(`MDAH_ADDR_OVERLOAD_THR, 32'h3e8);
        rc("ovl_max", `MDAH_ADDR_OVERLOAD_THR, `MDAH_OVERLOAD_MAX);
        wr(`MDAH_ADDR_POSDEV_THR, 32'h9c40);
        rc("dev_max", `MDAH_ADDR_POSDEV_THR, `MDAH_POSDEV_MAX);
        wr(`MDAH_ADDR_POSDEV_THR, 32'h0);
        rc("dev_min", `MDAH_ADDR_POSDEV_THR, `MDAH_POSDEV_MIN);
        $display("test registers done");
        wr(`MDAH_ADDR_NETLOSS_EN, 32'h0);
        pins <= 16'h0003;
        repeat (12) @(posedge clock);
        #1 chk("net_off", {31'h0, st_out}, 32'h1);
        pins <= 16'h0;
        repeat (6) @(posedge clock);
        wr(`MDAH_ADDR_NETLOSS_EN, 32'h1);
        $display("test loss detection off done");
        // every pin fault kind: raise, inspect, remove, clear
        for (int k = 0; k < 10; k++) begin
            @(posedge clock);
            pins <= pat[k];
            wait_st(1'b0);
            chk("status", {31'h0, st_out}, 32'h0);
            chk("outs", {28'h0, mot, rdy, stp, cur}, {30'h0, 1'b1, k < 7});
            chk("blinks", {28'h0, blinks}, {28'h0, `MDAH_BLINKS_STD});
            rc("code", `MDAH_ADDR_ALARM_CODE, {24'h0, cod[k]});
            if (k == 1) begin
                clear();
                chk("refused", {31'h0, st_out}, 32'h0);
            end
            @(posedge clock);
            pins <= 16'h0;
            repeat (6) @(posedge clock);
            clear();
            chk("cleared", {31'h0, st_out}, {31'h0, k < 7});
            rc("held", `MDAH_ADDR_ALARM_CODE, k < 7 ? 32'h0 : {24'h0, cod[k]});
            if (k == 0) begin
                rc("events", `MDAH_ADDR_EVENT, 32'h3);
                v0 = irq;
                wr(`MDAH_ADDR_MASK, 32'h7);
                repeat (2) @(posedge clock);
                #1 chk("irq_mask", {31'h0, irq}, {31'h0, ~v0});
                wr(`MDAH_ADDR_EVENT, 32'h7);
                wr(`MDAH_ADDR_MASK, 32'h0);
                rc("ev_w1c", `MDAH_ADDR_EVENT, 32'h0);
                chk("irq_off", {31'h0, irq}, 32'h0);
            end
            if (k >= 7) begin
                // cleared bit stays from earlier faults only until the first power cycle
                rc("locked", `MDAH_ADDR_EVENT, k == 7 ? 32'h7 : 32'h5);
                @(posedge clock);
                reset <= 1'b1;
                repeat (3) @(posedge clock);
                reset <= 1'b0;
                @(posedge clock);
                #1 chk("repower", {30'h0, st_out, cur}, 32'h3);
            end
            $display("test fault %0d done", k);
        end
        // short overload far below the threshold time must not raise an alarm
        @(posedge clock);
        ovl <= 1'b1;
        pos_dev <= 32'h12c;
        repeat (8) @(posedge clock);
        #1 chk("dev_eq", {31'h0, st_out}, 32'h1);
        chk("ovl_early", {31'h0, st_out}, 32'h1);
        @(posedge clock);
        ovl <= 1'b0;
        pos_dev <= 32'h12d;
        wait_st(1'b0);
        rc("dev_code", `MDAH_ADDR_ALARM_CODE, {24'h0, `MDAH_CODE_POSDEV});
        @(posedge clock);
        pos_dev <= 32'h0;
        clear();
        chk("dev_clr", {31'h0, st_out}, 32'h1);
        $display("test deviation done");
        close_out();
    end
endmodule : mdah_alarm_handler_bench
